/* verilog/fphr_pkg.sv */
package fphr_pkg;

    // ------------------------------------------------------------
    // Opcodes
    // ------------------------------------------------------------
    localparam logic [7:0] OP_ULTRA_SLEEP  = 8'h79;
    localparam logic [7:0] OP_SOFT_RESET   = 8'hF0;
    localparam logic [7:0] OP_RESET_CONFIRM = 8'hD0;
    localparam logic [7:0] OP_WRITE_STAT2  = 8'h31;

    // ------------------------------------------------------------
    // Field positions and reset values
    // ------------------------------------------------------------
    localparam int         STAT2_RESET_CMD_ENABLE_BIT  = 4;
    localparam logic       WEL_RESET       = 1'b0;
    localparam logic       RESET_CMD_ENABLE_RESET      = 1'b0;
    localparam logic [7:0] CFG_RESET       = 8'h00;

    // ------------------------------------------------------------
    // Timing, all in ns, converted at 100 MHz
    // ------------------------------------------------------------
    localparam int CLK_PERIOD_NS             = 10;
    localparam int ULTRA_SLEEP_ENTRY_TIME_NS = 3000;
    localparam int WAKE_PULSE_MIN_LOW_NS     = 20;
    localparam int ULTRA_SLEEP_EXIT_TIME_NS  = 100000;
    localparam int SOFT_RESET_STOP_TIME_NS   = 30000;
    localparam int ENTRY_CYCLES =
        (ULTRA_SLEEP_ENTRY_TIME_NS / CLK_PERIOD_NS) > 0 ?
        (ULTRA_SLEEP_ENTRY_TIME_NS / CLK_PERIOD_NS) : 1;
    localparam int WAKE_LOW_CYCLES =
        (WAKE_PULSE_MIN_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int EXIT_CYCLES_DEF =
        (ULTRA_SLEEP_EXIT_TIME_NS / CLK_PERIOD_NS) > 0 ?
        (ULTRA_SLEEP_EXIT_TIME_NS / CLK_PERIOD_NS) : 1;
    localparam int SRST_CYCLES =
        (SOFT_RESET_STOP_TIME_NS / CLK_PERIOD_NS) > 0 ?
        (SOFT_RESET_STOP_TIME_NS / CLK_PERIOD_NS) : 1;
    localparam int CNT_W = 24;

    // ------------------------------------------------------------
    // Power states
    // ------------------------------------------------------------
    typedef enum logic [1:0]
    {
        PWR_STANDBY  = 2'b00,
        PWR_ENTERING = 2'b01,
        PWR_ULTRA    = 2'b10,
        PWR_EXITING  = 2'b11
    } fphr_pwr_t;

endpackage

/* verilog/fphr_link_if.sv */
`timescale 1ns/100ps
`default_nettype none

// Sampled link events passed from front end to controller
interface fphr_link_if;
    logic       sel;
    logic       sel_rise;
    logic       sel_fall;
    logic       bit_strobe;
    logic       bit_val;
    logic       sck_low;
    logic       paused;
    logic       pause_abort;

    modport front
    (
        output sel, sel_rise, sel_fall, bit_strobe, bit_val, sck_low, paused, pause_abort
    );
    modport ctrl
    (
        input  sel, sel_rise, sel_fall, bit_strobe, bit_val, sck_low, paused, pause_abort
    );
endinterface

`default_nettype wire

/* verilog/fphr_link_front.sv */
`timescale 1ns/100ps
`default_nettype none

module fphr_link_front
    import fphr_pkg::*;
(
    input  wire logic   clk_in,
    input  wire logic   rst_in,
    input  wire logic   cs_n_in,
    input  wire logic   sck_in,
    input  wire logic   si_in,
    input  wire logic   hold_n_in,
    fphr_link_if.front  link
);

    typedef struct packed
    {
        logic [3:0] s1;
        logic [3:0] s2;
        logic       sel_d;
        logic       sck_d;
        logic       paused;
    } fphr_front_t;

    fphr_front_t st;
    fphr_front_t next_st;

    logic sel;
    logic sck;
    logic hold;

    // Second stage of the synchronisers
    assign sel  = ~st.s2[0];
    assign sck  = st.s2[1];
    assign hold = ~st.s2[3];

    // Sync, edge find and pause tracking
    always_comb
    begin
        next_st       = st;
        next_st.s1    = {hold_n_in, si_in, sck_in, cs_n_in};
        next_st.s2    = st.s1;
        next_st.sel_d = sel;
        next_st.sck_d = sck;
        if (!sel)
            next_st.paused = 1'b0;
        else if (!sck)
            next_st.paused = hold;
    end

    always_ff @(posedge clk_in or posedge rst_in)
    begin
        if (rst_in)
            st <= '{s1: 4'hF, s2: 4'hF, sel_d: 1'b0, sck_d: 1'b0, paused: 1'b0};
        else
            st <= next_st;
    end

    // Events toward the controller
    assign link.sel         = sel;
    assign link.sel_rise    = sel & ~st.sel_d;
    assign link.sel_fall    = ~sel & st.sel_d;
    assign link.sck_low     = ~sck;
    assign link.paused      = st.paused;
    assign link.bit_strobe  = sel & sck & ~st.sck_d & ~st.paused;
    assign link.bit_val     = st.s2[2];
    // Deselect seen while the pause pin is still held
    assign link.pause_abort = ~sel & st.sel_d & hold;

endmodule

`default_nettype wire

/* verilog/fphr_ctrl.sv */
`timescale 1ns/100ps
`default_nettype none

// What this block does
// - 79h then deselect enters ultra sleep
// - Ultra sleep ignores every command
// - Bits after sleep opcode are discarded
// - Short sleep opcode aborts, stay standby
// - Power-up always starts in standby
// - Sleep opcode ignored while busy
// - Select pulse wakes within exit time
// - Dummy byte during wake pulse ignored
// - Reselect before exit time is ignored
// - Early first bit wakes, command discarded
// - Power cycle restores all defaults
// - Pause never stops program or erase
// - Pause starts on clock-low while selected
// - Paused: output floats, inputs ignored
// - Pause ends on next clock-low phase
// - Deselect while paused aborts, clears latch
// - Soft reset stops cycle, only while busy
// - Soft reset needs enable bit set
// - F0h then D0h, later bytes ignored
// - Interrupted page contents undefined
// - Soft reset keeps config, clears latch
// - Soft reset needs whole bytes only
// - Standby when deselected and idle

module fphr_ctrl
    import fphr_pkg::*;
#(
    parameter int EXIT_CYCLES = EXIT_CYCLES_DEF
)
(
    input  wire logic        clk_in,
    input  wire logic        rst_in,
    input  wire logic        cs_n_in,
    input  wire logic        sck_in,
    input  wire logic        si_in,
    input  wire logic        hold_n_in,
    input  wire logic        wp_n_in,
    input  wire logic        busy_in,
    input  wire logic        wel_set_in,
    output logic             so_out,
    output logic             so_oe_out,
    output logic             write_enable_latch_out,
    output logic             reset_cmd_enable_out,
    output logic [7:0]       config_out,
    output logic             standby_out,
    output logic             ultra_sleep_out,
    output logic             paused_out,
    output logic             abort_cycle_out,
    output logic             page_undefined_out,
    output logic             cmd_blocked_out
);

    // ------------------------------------------------------------
    // Synchronisers and link events
    // ------------------------------------------------------------
    typedef struct packed
    {
        logic [1:0]       wp_sync;
        logic [2:0]       bit_cnt;
        logic [3:0]       byte_cnt;
        logic [7:0]       shift;
        logic [7:0]       op;
        logic             op2_ok;
        logic             stat2_data;
        logic             cmd_dead;
        fphr_pwr_t        pwr;
        logic [CNT_W-1:0] cnt;
        logic [CNT_W-1:0] low_cnt;
        logic             write_enable_latch;
        logic             reset_cmd_enable;
        logic [7:0]       cfg;
        logic             stopping;
        logic             abort_cycle;
        logic             page_undef;
    } fphr_ctrl_t;

    fphr_ctrl_t st;
    fphr_ctrl_t next_st;

    logic sel;
    logic sel_fall;
    logic sel_rise;
    logic bit_strobe;
    logic whole_bytes;
    logic [7:0] byte_now;

    fphr_link_if link ();

    // Decode of a complete opcode byte
    function automatic logic is_op(input logic [7:0] b, input logic [7:0] code);
        is_op = (b == code);
    endfunction

    // Pin front end: sync, edges and pause
    fphr_link_front u_front
    (
        .clk_in    (clk_in),
        .rst_in    (rst_in),
        .cs_n_in   (cs_n_in),
        .sck_in    (sck_in),
        .si_in     (si_in),
        .hold_n_in (hold_n_in),
        .link      (link)
    );

    // Link events used by the decoder
    assign sel         = link.sel;
    assign sel_rise    = link.sel_rise;
    assign sel_fall    = link.sel_fall;
    assign bit_strobe  = link.bit_strobe;
    assign byte_now    = {st.shift[6:0], link.bit_val};
    assign whole_bytes = (st.bit_cnt == 3'd0);

    // ------------------------------------------------------------
    // Next-state logic
    // ------------------------------------------------------------
    always_comb
    begin
        next_st         = st;
        next_st.wp_sync = {st.wp_sync[0], wp_n_in};
        next_st.abort_cycle = 1'b0;

        // Serial shift while selected and not paused
        if (sel_rise)
        begin
            next_st.bit_cnt  = 3'd0;
            next_st.byte_cnt = 4'd0;
            next_st.op       = 8'h00;
            next_st.op2_ok   = 1'b0;
            next_st.stat2_data = 1'b0;
            // Ultra sleep frames die on their first early bit instead
            next_st.cmd_dead = (st.pwr == PWR_ENTERING)
                             | (st.pwr == PWR_EXITING);
            next_st.low_cnt  = '0;
        end
        else if (sel)
        begin
            if (st.low_cnt != {CNT_W{1'b1}})
                next_st.low_cnt = st.low_cnt + 1'b1;
        end

        if (bit_strobe)
        begin
            next_st.shift   = byte_now;
            next_st.bit_cnt = st.bit_cnt + 3'd1;
            if (st.pwr == PWR_ULTRA || st.pwr == PWR_ENTERING)
                next_st.cmd_dead = 1'b1;
            if (st.bit_cnt == 3'd7 && !st.cmd_dead && st.pwr == PWR_STANDBY)
            begin
                if (st.byte_cnt != 4'hF)
                    next_st.byte_cnt = st.byte_cnt + 4'd1;
                if (st.byte_cnt == 4'd0)
                    next_st.op = byte_now;
                if (st.byte_cnt == 4'd1 && is_op(st.op, OP_SOFT_RESET))
                    next_st.op2_ok = is_op(byte_now, OP_RESET_CONFIRM);
                if (st.byte_cnt == 4'd1 && is_op(st.op, OP_WRITE_STAT2) && st.write_enable_latch)
                begin
                    next_st.stat2_data = 1'b1;
                    next_st.reset_cmd_enable = byte_now[STAT2_RESET_CMD_ENABLE_BIT];
                    next_st.write_enable_latch  = WEL_RESET;
                end
            end
        end

        // Latch set request from the rest of the device
        if (wel_set_in)
            next_st.write_enable_latch = 1'b1;

        // Deselect: decide what the finished frame means
        if (sel_fall)
        begin
            if (link.pause_abort)
            begin
                next_st.write_enable_latch = WEL_RESET;
            end
            else if (!st.cmd_dead && st.pwr == PWR_STANDBY)
            begin
                // Trailing bits beyond the opcode do not matter
                if (st.byte_cnt != 4'd0 && is_op(st.op, OP_ULTRA_SLEEP)
                    && !busy_in)
                begin
                    next_st.pwr = PWR_ENTERING;
                    next_st.cnt = CNT_W'(ENTRY_CYCLES);
                end
                if (is_op(st.op, OP_SOFT_RESET) && st.op2_ok && whole_bytes
                    && st.reset_cmd_enable && busy_in)
                begin
                    next_st.stopping = 1'b1;
                    next_st.cnt      = CNT_W'(SRST_CYCLES);
                    next_st.write_enable_latch      = WEL_RESET;
                end
            end
            // Wake pulse: any long enough select from ultra sleep
            if (st.pwr == PWR_ULTRA && st.low_cnt >= CNT_W'(WAKE_LOW_CYCLES))
            begin
                next_st.pwr = PWR_EXITING;
                next_st.cnt = CNT_W'(EXIT_CYCLES);
            end
        end

        // Select held low through the exit time also wakes
        if (sel && st.pwr == PWR_ULTRA && !sel_rise
            && st.low_cnt >= CNT_W'(EXIT_CYCLES))
            next_st.pwr = PWR_STANDBY;

        // New selection clears the page flag; a fresh abort still sets it
        if (st.page_undef && sel_rise)
            next_st.page_undef = 1'b0;

        // Power and soft reset timers
        case (st.pwr)
            PWR_ENTERING:
            begin
                if (st.cnt <= 1)
                    next_st.pwr = PWR_ULTRA;
                else
                    next_st.cnt = st.cnt - 1'b1;
            end
            PWR_EXITING:
            begin
                if (st.cnt <= 1)
                    next_st.pwr = PWR_STANDBY;
                else
                    next_st.cnt = st.cnt - 1'b1;
            end
            PWR_ULTRA, PWR_STANDBY:
            begin
                if (st.stopping)
                begin
                    if (st.cnt <= 1)
                    begin
                        next_st.stopping    = 1'b0;
                        next_st.abort_cycle = 1'b1;
                        next_st.page_undef  = 1'b1;
                    end
                    else
                        next_st.cnt = st.cnt - 1'b1;
                end
            end
            default:
                next_st.pwr = PWR_STANDBY;
        endcase
    end

    // ------------------------------------------------------------
    // State register
    // ------------------------------------------------------------
    always_ff @(posedge clk_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            st      <= '0;
            st.wp_sync <= 2'h3;
            st.pwr  <= PWR_STANDBY;
            st.write_enable_latch  <= WEL_RESET;
            st.reset_cmd_enable <= RESET_CMD_ENABLE_RESET;
            st.cfg  <= CFG_RESET;
        end
        else
            st <= next_st;
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    // Serial output is never driven here; paused keeps it floating
    assign so_out                 = 1'b0;
    assign so_oe_out              = 1'b0;
    assign write_enable_latch_out = st.write_enable_latch;
    assign reset_cmd_enable_out   = st.reset_cmd_enable;
    assign config_out             = st.cfg;
    assign standby_out            = (st.pwr == PWR_STANDBY) & ~sel & ~busy_in;
    assign ultra_sleep_out        = (st.pwr == PWR_ULTRA);
    assign paused_out             = link.paused;
    assign abort_cycle_out        = st.abort_cycle;
    assign page_undefined_out     = st.page_undef;
    assign cmd_blocked_out        = st.cmd_dead;

endmodule

`default_nettype wire

/* sim/fphr_ctrl_properties.sv */
`timescale 1ns/100ps
`default_nettype none

module fphr_ctrl_properties
#(
    parameter int EXIT_CYCLES = 50
)
(
    input wire logic       clk_in,
    input wire logic       rst_in,
    input wire logic       cs_n_in,
    input wire logic       busy_in,
    input wire logic       so_oe_out,
    input wire logic       write_enable_latch_out,
    input wire logic       reset_cmd_enable_out,
    input wire logic [7:0] config_out,
    input wire logic       ultra_sleep_out,
    input wire logic       paused_out,
    input wire logic       abort_cycle_out,
    input wire logic       page_undefined_out,
    input wire logic       standby_out
);
    // ----------------------------------------
    // Port relations
    // ----------------------------------------
    default clocking cb @(posedge clk_in);
    endclocking
    default disable iff (rst_in);

    property p_float; paused_out |-> !so_oe_out; endproperty
    a_float: assert property (p_float) else $error("output driven while paused");
    property p_abort_busy; abort_cycle_out |-> $past(busy_in); endproperty
    a_abort_busy: assert property (p_abort_busy) else $error("abort while idle");
    property p_abort_en; abort_cycle_out |-> reset_cmd_enable_out; endproperty
    a_abort_en: assert property (p_abort_en) else $error("abort without enable");
    property p_wel; abort_cycle_out |=> !write_enable_latch_out; endproperty
    a_wel: assert property (p_wel) else $error("latch kept after abort");
    property p_keep; abort_cycle_out |=> $stable(config_out) && reset_cmd_enable_out; endproperty
    a_keep: assert property (p_keep) else $error("config changed by abort");
    property p_page; abort_cycle_out |=> page_undefined_out; endproperty
    a_page: assert property (p_page) else $error("page flag missing");
    property p_dead; ultra_sleep_out |-> !abort_cycle_out && !standby_out; endproperty
    a_dead: assert property (p_dead) else $error("activity in ultra sleep");
    property p_desel; cs_n_in [*5] |=> !paused_out; endproperty
    a_desel: assert property (p_desel) else $error("paused while deselected");
    property p_hold_wel;
        paused_out && $rose(cs_n_in) |-> ##[1:8] !write_enable_latch_out;
    endproperty
    a_hold_wel: assert property (p_hold_wel) else $error("latch kept on paused exit");

    // Main scenarios reached
    c_sleep: cover property ($rose(ultra_sleep_out));
    c_abort: cover property (abort_cycle_out);
    c_pause: cover property ($rose(paused_out));
endmodule

bind fphr_ctrl fphr_ctrl_properties #(.EXIT_CYCLES(EXIT_CYCLES)) u_props
(
    .clk_in(clk_in), .rst_in(rst_in), .cs_n_in(cs_n_in), .busy_in(busy_in),
    .so_oe_out(so_oe_out), .write_enable_latch_out(write_enable_latch_out),
    .reset_cmd_enable_out(reset_cmd_enable_out), .config_out(config_out),
    .ultra_sleep_out(ultra_sleep_out), .paused_out(paused_out),
    .abort_cycle_out(abort_cycle_out), .page_undefined_out(page_undefined_out),
    .standby_out(standby_out)
);

`default_nettype wire

/* sim/fphr_host_model.sv */
`timescale 1ns/100ps
`default_nettype none

module fphr_host_model
(
    input  wire logic clk_in,
    output logic      cs_n_out,
    output logic      sck_out,
    output logic      si_out,
    output logic      hold_n_out
);
    // ----------------------------------------
    // Host frames, clock still between frames
    // ----------------------------------------
    initial
    begin
        cs_n_out = 1'b1;
        sck_out = 1'b0;
        si_out = 1'b0;
        hold_n_out = 1'b1;
    end

    task automatic w(input int n);
        repeat (n) @(posedge clk_in);
    endtask

    // Left-aligned data, n bits MSB first; pause at bit hb, deselect if ab
    task automatic frame(input logic [31:0] d, input int n, input int hb, input bit ab);
        cs_n_out <= 1'b0;
        w(4); // Low time of two cycles at least
        for (int i = 0; i < n; i++)
        begin
            if (i == hb)
            begin
                hold_n_out <= 1'b0;
                repeat (3)
                begin
                    w(4);
                    sck_out <= 1'b1;
                    si_out <= ~si_out;
                    w(4);
                    sck_out <= 1'b0;
                end
                w(4);
                if (ab)
                begin
                    cs_n_out <= 1'b1;
                    w(4);
                    hold_n_out <= 1'b1;
                    w(8);
                    return;
                end
                hold_n_out <= 1'b1;
            end
            si_out <= d[31-i];
            w(4);
            sck_out <= 1'b1;
            w(4);
            sck_out <= 1'b0;
        end
        w(4);
        cs_n_out <= 1'b1;
        si_out <= ~si_out; // Released line shows no stale bit
        w(8);
    endtask
endmodule

`default_nettype wire

/* sim/tb_top.sv */
`timescale 1ns/100ps
`default_nettype none

module tb_top;
    import fphr_pkg::*;
    // ----------------------------------------
    // Clock, pins and counters
    // ----------------------------------------
    logic       clk_in = 1'b0;
    logic       rst_in = 1'b1;
    logic       busy = 1'b0;
    logic       wel_set = 1'b0;
    logic       wp_n = 1'b1;
    logic       cs_n, sck, si, hold_n, so, so_oe, write_enable_latch, reset_cmd_enable, stby, ultra, paused, abort;
    logic       page, blk;
    logic [7:0] cfg;
    int         fail_count = 0;
    int         cmp_count = 0;
    int         aborts = 0;
    int         cyc = 0;
    bit         seen_pause = 0;
    localparam logic [31:0] SRST = {OP_SOFT_RESET, OP_RESET_CONFIRM, 16'h0000};

    always #5 clk_in = ~clk_in;

    fphr_host_model host (.clk_in(clk_in), .cs_n_out(cs_n), .sck_out(sck), .si_out(si),
        .hold_n_out(hold_n));
    fphr_ctrl #(.EXIT_CYCLES(50)) dut (.clk_in(clk_in), .rst_in(rst_in), .cs_n_in(cs_n),
        .sck_in(sck), .si_in(si), .hold_n_in(hold_n), .wp_n_in(wp_n), .busy_in(busy),
        .wel_set_in(wel_set), .so_out(so), .so_oe_out(so_oe), .write_enable_latch_out(write_enable_latch),
        .reset_cmd_enable_out(reset_cmd_enable), .config_out(cfg), .standby_out(stby),
        .ultra_sleep_out(ultra), .paused_out(paused), .abort_cycle_out(abort),
        .page_undefined_out(page), .cmd_blocked_out(blk));

    // Event counts and hang limit
    always @(posedge clk_in)
    begin
        cyc++;
        if (abort === 1'b1) aborts++;
        if (paused === 1'b1) seen_pause = 1;
        if (cyc == 40000)
        begin
            fail_count++;
            close_out();
        end
    end

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        cmp_count++;
        if (got !== exp)
        begin
            fail_count++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask

    task automatic w(input int n);
        repeat (n) @(posedge clk_in);
    endtask

    task automatic go(input logic [31:0] d, input int n, input int hb = -1, input bit ab = 0);
        host.frame(d, n, hb, ab);
        w(10);
    endtask

    task automatic wel_on();
        wel_set <= 1'b1;
        w(1);
        wel_set <= 1'b0;
        w(1);
    endtask

    // Whether a frame must end the running cycle
    function automatic int exp_abort(input logic b, input logic [31:0] d, input int n);
        return int'(b && n % 8 == 0 && n >= 16 && d[31:16] == 16'hF0D0);
    endfunction

    task automatic close_out();
        $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
        if (fail_count == 0 && cmp_count > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    initial
    begin
        int e;
        int n;
        int lens[4] = '{12, 15, 17, 23};
        logic [31:0] d;
        logic b;
        void'($urandom(32'h45D8));
        w(3);
        rst_in <= 1'b0;
        w(4);
        chk({stby, ultra, write_enable_latch, reset_cmd_enable}, 8'h08);
        chk(cfg, 8'h00);
        busy <= 1'b1;
        go(SRST, 16);
        w(SRST_CYCLES);
        chk(8'(aborts), 8'h00);
        busy <= 1'b0;
        wel_on();
        go({OP_WRITE_STAT2, 8'h10, 16'h0000}, 16);
        chk({reset_cmd_enable, write_enable_latch, blk}, 8'h04);
        busy <= 1'b1;
        wel_on();
        go({OP_SOFT_RESET, OP_RESET_CONFIRM, 8'($urandom), 8'h00}, 24);
        w(SRST_CYCLES);
        chk(8'(aborts), 8'h01);
        chk({write_enable_latch, reset_cmd_enable, page}, 8'h03);
        chk(cfg, 8'h00);
        e = 1;
        foreach (lens[k])
        begin
            go(SRST, lens[k]);
            e += exp_abort(1'b1, SRST, lens[k]);
            chk(8'(aborts), 8'(e));
        end
        wel_on();
        go(SRST, 16, 3, 1);
        chk({write_enable_latch, paused}, 8'h00);
        chk(8'(aborts), 8'(e));
        go(SRST, 16, 5, 0);
        w(SRST_CYCLES);
        e++;
        chk(8'(aborts), 8'(e));
        chk(8'(seen_pause), 8'h01);
        chk({so, so_oe}, 8'h00);
        go({OP_ULTRA_SLEEP, 24'h0}, 8);
        w(310);
        chk(8'(ultra), 8'h00);
        busy <= 1'b0;
        go({OP_ULTRA_SLEEP, 24'h0}, 5);
        w(310);
        chk({ultra, stby}, 8'h01);
        for (int k = 0; k < 3; k++)
        begin
            go({OP_ULTRA_SLEEP, 24'($urandom)}, 16);
            w(ENTRY_CYCLES);
            chk({ultra, stby}, 8'h02);
            busy <= 1'b1;
            if (k == 1) go(32'h0, 0);
            go((k == 0) ? 32'h0 : SRST, (k == 0) ? 8 : 16);
            chk(8'(aborts), 8'(e));
            chk(8'(blk), 8'h01);
            w(60);
            busy <= 1'b0;
            w(2);
            chk({ultra, stby}, 8'h01);
        end
        repeat (6)
        begin
            d = {8'hF0, ($urandom % 2) ? 8'hD0 : 8'($urandom), 16'($urandom)};
            n = 14 + $urandom % 5;
            b = 1'($urandom);
            busy <= b;
            wp_n <= 1'($urandom);
            go(d, n);
            if (exp_abort(b, d, n) != 0) w(SRST_CYCLES);
            e += exp_abort(b, d, n);
            chk(8'(aborts), 8'(e));
        end
        rst_in <= 1'b1;
        w(3);
        rst_in <= 1'b0;
        busy <= 1'b0;
        w(4);
        chk({reset_cmd_enable, ultra, stby}, 8'h01);
        close_out();
    end
endmodule

`default_nettype wire
